// file: core/swfp_pkg.sv
// Constants shared by the switch fault-protection control block.
// Assumes a 200 MHz system clock and an AHB-Lite register bus with 32-bit data.
package swfp_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 5;
    localparam int SC_RESP_NS      = 5000;
    localparam int SC_RESP_CYC     = SC_RESP_NS / CLK_PERIOD_NS;
    localparam int FLT_DEASSERT_NS = 1000;
    localparam int FLT_DEASSERT_CYC =
        (FLT_DEASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RETRY_CYCLES    = 32;
    localparam int TMR_HIGH_MV     = 1200;
    localparam int TMR_LOW_MV      = 200;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_OC_STRT = 8'h04;
    localparam logic [7:0] OFS_I2T_TRP = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;

    localparam int CTRL_LATCH_BIT  = 0;
    localparam int ST_TRIP_BIT     = 0;
    localparam int ST_OT_BIT       = 1;
    localparam int ST_UV_BIT       = 2;
    localparam int ST_FLTPIN_BIT   = 3;
    localparam int ST_MODE_LSB     = 4;
    localparam int ST_RETRY_LSB    = 6;
    localparam int ST_LATCHOFF_BIT = 11;

    localparam logic        RST_LATCH_OFF = 1'b0;
    localparam logic [11:0] RST_OC_START  = 12'h100;
    localparam logic [31:0] RST_I2T_TRIP  = 32'h0010_0000;

    // ************************************************************
    // Operating modes
    // ************************************************************
    typedef enum logic [1:0] {
        SWFP_SHUTDOWN,
        SWFP_LOW_POWER,
        SWFP_LOAD_WAKEUP,
        SWFP_ACTIVE
    } swfp_mode_t;

endpackage

// file: core/swfp_sync.sv
// Two-stage synchroniser bank for asynchronous pin and comparator levels.
// Assumes each bit is a slow level; multi-bit words are not made coherent.
`timescale 1ns/1ps
`default_nettype none
module swfp_sync
#(
    parameter int W = 1
)
(
    input  wire logic         clk_sys,  // System clock
    input  wire logic         arst_n,   // Asynchronous reset, active low
    input  wire logic [W-1:0] d_async,  // Asynchronous levels
    output logic      [W-1:0] q_sync    // Synchronised levels
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_reg <= '0;
            q_sync   <= '0;
        end
        else
        begin
            meta_reg <= d_async;
            q_sync   <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// file: core/swfp_ctrl.sv
// Fault-protection control for a high-side power switch controller.
// Assumes comparator outputs arrive as asynchronous levels and the load
// current code comes from an on-chip converter on clk_sys.
//
// Notes on behaviour
// - Above start level, integrator grows by load squared minus start squared.
// - Integrator at trip level turns main gate off and asserts fault together.
// - After auto-retry trip, timer ramps up then down between levels, repeating.
// - After 32 ramp cycles main gate returns; fault releases after a delay.
// - On-request fall, low-power entry, enable loss or power cycle clear latch.
// - After clearing, host raises on-request again and main gate turns on.
// - Short circuit turns main gate off quickly with fault flag at once.
// - Short-circuit trip uses the same retry or latch-off handling.
// - Current monitor enabled only in active mode and load wakeup.
// - Direction pin released high for forward current, pulled low for reverse.
// - Temperature amplifier enabled only in active mode and load wakeup.
// - Overtemperature turns main gate off, asserts fault, always latches off.
// - Overtemperature latch clears on the same events as other latches.
// - Charge-pump undervoltage asserts fault and disables both gate drives.
// - Charge-pump recovery releases fault and gates automatically, no latch.
// - Low-power mode keeps main gate off, bypass on, wake indication high.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module swfp_ctrl
    import swfp_pkg::*;
#(
    parameter int          LOAD_W      = 12,
    parameter int          RETRY_HALF  = 8000,
    parameter int          DEASSERT    = FLT_DEASSERT_CYC
)
(
    input  wire logic              clk_sys,                // System clock, 200 MHz
    input  wire logic              arst_n,                 // Asynchronous reset
    input  wire logic              on_request_in,          // Main switch request
    input  wire logic              low_power_request_n,    // Low means low-power mode
    input  wire logic              enable_undervoltage_in, // Enable above threshold
    input  wire logic              supply_good_in,         // Supply above power-on level
    input  wire logic              short_circuit_cmp,      // Load above short level
    input  wire logic              overtemp_cmp,           // Temperature output too high
    input  wire logic              charge_pump_uv_cmp,     // Charge pump undervoltage
    input  wire logic              current_forward_cmp,    // Forward sense current
    input  wire logic              load_wakeup_cmp,        // Bypass current above wakeup
    input  wire logic              latch_off_strap,        // Timer pin strapped to ground
    input  wire logic [LOAD_W-1:0] load_current_code,      // Load current magnitude
    output logic                   main_gate_en,           // Main gate drive on
    output logic                   bypass_gate_en,         // Bypass gate drive on
    output logic                   wake_out,               // Wake indication
    output logic                   load_current_monitor,   // Current monitor enable
    output logic                   temp_monitor_en,        // Temperature amplifier enable
    input  wire logic              fault_flag_n_in,        // Fault pin level read back
    output logic                   fault_flag_n_o,         // Fault pin drive value
    output logic                   fault_flag_n_oe,        // Fault pin pulled low
    output logic                   current_dir_o,          // Direction pin drive value
    output logic                   current_dir_oe,         // Direction pin pulled low
    input  wire logic              hsel,                   // AHB select
    input  wire logic [7:0]        haddr,                  // AHB address
    input  wire logic [1:0]        htrans,                 // AHB transfer type
    input  wire logic              hwrite,                 // AHB write
    input  wire logic [2:0]        hsize,                  // AHB size
    input  wire logic              hready,                 // AHB bus ready
    input  wire logic [31:0]       hwdata,                 // AHB write data
    output logic      [31:0]       hrdata,                 // AHB read data
    output logic                   hreadyout,              // AHB slave ready
    output logic                   hresp                   // AHB response
);

    localparam int TMR_W = $clog2(RETRY_HALF + 1);
    localparam int DLY_W = $clog2(DEASSERT + 1);
    localparam int SQ_W  = 2 * LOAD_W;

    // ************************************************************
    // Input synchronisation
    // ************************************************************
    logic [10:0] raw_in;
    logic [10:0] sync_in;
    logic        on_s;
    logic        lpm_n_s;
    logic        en_s;
    logic        sup_s;
    logic        sc_s;
    logic        ot_s;
    logic        uv_s;
    logic        fwd_s;
    logic        lwu_s;
    logic        strap_s;
    logic        fpin_s;

    assign raw_in = {fault_flag_n_in, latch_off_strap, load_wakeup_cmp,
                     current_forward_cmp, charge_pump_uv_cmp, overtemp_cmp,
                     short_circuit_cmp, supply_good_in, enable_undervoltage_in,
                     low_power_request_n, on_request_in};

    // Every comparator level passes two flip-flops first.
    swfp_sync #(.W(11)) u_sync
    (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .d_async (raw_in),
        .q_sync  (sync_in)
    );

    assign {fpin_s, strap_s, lwu_s, fwd_s, uv_s, ot_s, sc_s, sup_s, en_s,
            lpm_n_s, on_s} = sync_in;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        swfp_mode_t        mode;
        logic              trip;
        logic              ot_latch;
        logic              fault_hold;
        logic [DLY_W-1:0]  dly_cnt;
        logic [31:0]       integ;
        logic [TMR_W-1:0]  tmr_cnt;
        logic              tmr_up;
        logic [4:0]        retry_cnt;
        logic              on_d;
        logic              lpm_n_d;
        logic              latch_cfg;
        logic [LOAD_W-1:0] oc_start;
        logic [31:0]       i2t_trip;
        logic              wr_pend;
        logic [7:0]        wr_addr;
        logic [31:0]       hrdata;
        logic              main_en;
        logic              bypass_en;
        logic              wake;
        logic              load_current_monitor_en;
        logic              tmon_en;
        logic              fault_oe;
        logic              dir_oe;
        logic              hreadyout;
    } swfp_state_t;

    swfp_state_t q_reg;
    swfp_state_t q_next;

    // Excess of load current squared over start current squared, floored at zero.
    function automatic logic [SQ_W-1:0] sq_excess(input logic [LOAD_W-1:0] ld,
                                                   input logic [LOAD_W-1:0] st);
        logic [SQ_W-1:0] a;
        logic [SQ_W-1:0] b;
        a = SQ_W'(ld) * SQ_W'(ld);
        b = SQ_W'(st) * SQ_W'(st);
        return (a > b) ? (a - b) : '0;
    endfunction

    logic clear_evt;
    logic latch_off;
    logic live;
    logic above;
    logic bus_go;

    assign clear_evt = (q_reg.on_d && !on_s) || (q_reg.lpm_n_d && !lpm_n_s)
                       || !en_s || !sup_s;
    assign latch_off = strap_s || q_reg.latch_cfg;
    assign live      = (q_reg.mode == SWFP_ACTIVE) || (q_reg.mode == SWFP_LOAD_WAKEUP);
    assign above     = load_current_code > q_reg.oc_start;
    assign bus_go    = hsel && htrans[1] && hready;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        q_next         = q_reg;
        q_next.on_d    = on_s;
        q_next.lpm_n_d = lpm_n_s;

        case (q_reg.mode)
            SWFP_SHUTDOWN:
                q_next.mode = lpm_n_s ? SWFP_ACTIVE : SWFP_LOW_POWER;
            SWFP_LOW_POWER:
                if (lpm_n_s)
                    q_next.mode = SWFP_ACTIVE;
                else if (lwu_s)
                    q_next.mode = SWFP_LOAD_WAKEUP;
            SWFP_LOAD_WAKEUP:
                if (lpm_n_s)
                    q_next.mode = SWFP_ACTIVE;
            SWFP_ACTIVE:
                if (!lpm_n_s)
                    q_next.mode = SWFP_LOW_POWER;
            default:
                q_next.mode = SWFP_SHUTDOWN;
        endcase
        if (!en_s || !sup_s)
            q_next.mode = SWFP_SHUTDOWN;

        // Latch clear first so that a trip in the same cycle still wins.
        if (clear_evt)
        begin
            q_next.trip       = 1'b0;
            q_next.ot_latch   = 1'b0;
            q_next.fault_hold = 1'b0;
            q_next.retry_cnt  = '0;
            q_next.tmr_cnt    = '0;
            q_next.tmr_up     = 1'b1;
            q_next.integ      = '0;
        end

        if (live && above && !q_reg.trip)
            q_next.integ = q_reg.integ + 32'(sq_excess(load_current_code,
                                                       q_reg.oc_start));
        else if (!above)
            q_next.integ = '0;

        if (live && !q_reg.trip && ((q_reg.integ >= q_reg.i2t_trip)
            || sc_s))
        begin
            q_next.trip      = 1'b1;
            q_next.integ     = '0;
            q_next.retry_cnt = '0;
            q_next.tmr_cnt   = '0;
            q_next.tmr_up    = 1'b1;
        end
        else if (q_reg.trip && !clear_evt && !latch_off)
        begin
            if (q_reg.tmr_up)
            begin
                q_next.tmr_cnt = q_reg.tmr_cnt + 1'b1;
                if (q_reg.tmr_cnt == TMR_W'(RETRY_HALF - 1))
                    q_next.tmr_up = 1'b0;
            end
            else
            begin
                q_next.tmr_cnt = q_reg.tmr_cnt - 1'b1;
                if (q_reg.tmr_cnt == TMR_W'(1))
                begin
                    q_next.tmr_up    = 1'b1;
                    q_next.retry_cnt = q_reg.retry_cnt + 1'b1;
                    if (q_reg.retry_cnt == 5'(RETRY_CYCLES - 1))
                    begin
                        q_next.trip       = 1'b0;
                        q_next.fault_hold = 1'b1;
                        q_next.dly_cnt    = '0;
                    end
                end
            end
        end

        if (live && ot_s)
            q_next.ot_latch = 1'b1;

        if (q_reg.fault_hold && !clear_evt)
        begin
            q_next.dly_cnt = q_reg.dly_cnt + 1'b1;
            if (q_reg.dly_cnt == DLY_W'(DEASSERT - 1))
                q_next.fault_hold = 1'b0;
        end

        // Pin outputs follow the next state so they change with it.
        q_next.main_en   = ((q_next.mode == SWFP_ACTIVE && on_s)
                            || q_next.mode == SWFP_LOAD_WAKEUP)
                           && !q_next.trip && !q_next.ot_latch && !uv_s;
        q_next.bypass_en = (q_next.mode == SWFP_LOW_POWER) && !uv_s
                           && !q_next.trip;
        q_next.wake      = q_next.mode == SWFP_LOW_POWER;
        q_next.load_current_monitor_en   = (q_next.mode == SWFP_ACTIVE)
                           || (q_next.mode == SWFP_LOAD_WAKEUP);
        q_next.tmon_en   = q_next.load_current_monitor_en;
        q_next.fault_oe  = q_next.trip || q_next.ot_latch || q_next.fault_hold
                           || (uv_s && q_next.mode != SWFP_SHUTDOWN);
        q_next.dir_oe    = !fwd_s;

        // AHB-Lite slave: zero wait states, always OKAY.
        q_next.hreadyout = 1'b1;
        q_next.wr_pend   = bus_go && hwrite;
        q_next.wr_addr   = haddr;
        q_next.hrdata    = '0;
        if (bus_go && !hwrite)
        begin
            case ({haddr[7:2], 2'b00})
                OFS_CTRL:    q_next.hrdata[CTRL_LATCH_BIT] = q_reg.latch_cfg;
                OFS_OC_STRT: q_next.hrdata[LOAD_W-1:0] = q_reg.oc_start;
                OFS_I2T_TRP: q_next.hrdata = q_reg.i2t_trip;
                OFS_STATUS:
                begin
                    q_next.hrdata[ST_TRIP_BIT]     = q_reg.trip;
                    q_next.hrdata[ST_OT_BIT]       = q_reg.ot_latch;
                    q_next.hrdata[ST_UV_BIT]       = uv_s;
                    q_next.hrdata[ST_FLTPIN_BIT]   = fpin_s;
                    q_next.hrdata[ST_MODE_LSB+:2]  = q_reg.mode;
                    q_next.hrdata[ST_RETRY_LSB+:5] = q_reg.retry_cnt;
                    q_next.hrdata[ST_LATCHOFF_BIT] = latch_off;
                end
                default:     q_next.hrdata = '0;
            endcase
        end
        if (q_reg.wr_pend)
        begin
            case ({q_reg.wr_addr[7:2], 2'b00})
                OFS_CTRL:    q_next.latch_cfg = hwdata[CTRL_LATCH_BIT];
                OFS_OC_STRT: q_next.oc_start  = hwdata[LOAD_W-1:0];
                OFS_I2T_TRP: q_next.i2t_trip  = hwdata;
                default:     q_next.latch_cfg = q_reg.latch_cfg;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q_reg           <= '0;
            q_reg.mode      <= SWFP_SHUTDOWN;
            q_reg.tmr_up    <= 1'b1;
            q_reg.latch_cfg <= RST_LATCH_OFF;
            q_reg.oc_start  <= RST_OC_START[LOAD_W-1:0];
            q_reg.i2t_trip  <= RST_I2T_TRIP;
            q_reg.hreadyout <= 1'b1;
        end
        else
            q_reg <= q_next;
    end

    assign main_gate_en         = q_reg.main_en;
    assign bypass_gate_en       = q_reg.bypass_en;
    assign wake_out             = q_reg.wake;
    assign load_current_monitor = q_reg.load_current_monitor_en;
    assign temp_monitor_en      = q_reg.tmon_en;
    assign fault_flag_n_o       = 1'b0;
    assign fault_flag_n_oe      = q_reg.fault_oe;
    assign current_dir_o        = 1'b0;
    assign current_dir_oe       = q_reg.dir_oe;
    assign hrdata               = q_reg.hrdata;
    assign hreadyout            = q_reg.hreadyout;
    assign hresp                = 1'b0;

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_SC_TRIP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        live && sc_s |=> !main_gate_en && fault_flag_n_oe)
        else $error("Short circuit did not trip the main gate");

    AST_I2T_TRIP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        live && !q_reg.trip && q_reg.integ >= q_reg.i2t_trip
        |=> q_reg.trip && !main_gate_en && fault_flag_n_oe)
        else $error("Integrator reached trip level without a trip");

    AST_I2T_ACCUM: assert property (@(posedge clk_sys) disable iff (!arst_n)
        live && above && !q_reg.trip && !clear_evt && q_reg.integ < q_reg.i2t_trip && !sc_s
        |=> q_reg.integ == $past(q_reg.integ)
            + 32'(sq_excess($past(load_current_code), $past(q_reg.oc_start))))
        else $error("Integrator did not accumulate the squared excess");

    AST_OT_LATCH: assert property (@(posedge clk_sys) disable iff (!arst_n)
        q_reg.ot_latch && !clear_evt |=> q_reg.ot_latch && !main_gate_en)
        else $error("Overtemperature latch released without a clear event");

    AST_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clear_evt && !live |=> !q_reg.trip && q_reg.retry_cnt == 5'h00
                               && q_reg.tmr_cnt == '0)
        else $error("Clear event did not reset the latch and timer");

    AST_UV_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
        uv_s && en_s && sup_s ##1 uv_s |-> !main_gate_en && !bypass_gate_en && fault_flag_n_oe)
        else $error("Charge-pump undervoltage left a gate on");

    AST_ACTIVE_ON: assert property (@(posedge clk_sys) disable iff (!arst_n)
        q_reg.mode == SWFP_ACTIVE && lpm_n_s && en_s && sup_s && on_s && !uv_s && !sc_s
        && !q_reg.trip && !q_reg.ot_latch && !ot_s && q_reg.integ < q_reg.i2t_trip
        |=> main_gate_en)
        else $error("Main gate not on with request and no fault");

    AST_LPM: assert property (@(posedge clk_sys) disable iff (!arst_n)
        q_reg.mode == SWFP_LOW_POWER |-> !main_gate_en && wake_out)
        else $error("Low-power mode drove the main gate or dropped wake");

    AST_MON: assert property (@(posedge clk_sys) disable iff (!arst_n)
        q_reg.mode == SWFP_SHUTDOWN || q_reg.mode == SWFP_LOW_POWER
        |-> !load_current_monitor && !temp_monitor_en)
        else $error("Monitor enabled outside active or wakeup");

    AST_DIR: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !fwd_s |=> current_dir_oe)
        else $error("Reverse current not shown on direction pin");

endmodule
`default_nettype wire

// file: tb/swfp_host.sv
// Host-side pin model: pull-ups on the open-drain fault and direction pins.
// Assumes the block pulls each pin low only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module swfp_host
(
    input  wire logic flt_oe,  // Fault pin pulled low
    input  wire logic dir_oe,  // Direction pin pulled low
    output logic      flt_pin, // Fault pin level
    output logic      dir_pin  // Direction pin level
);
    // A released pin rises to the pull-up level.
    assign flt_pin = !flt_oe;
    assign dir_pin = !dir_oe;
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the fault-protection controller.
// Assumes the host pin model and zero-wait register access.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import swfp_pkg::*;
    logic        clk_sys = 0, arst_n = 0, on_request_in = 0, low_power_request_n = 1;
    logic        enable_undervoltage_in = 0, supply_good_in = 0, short_circuit_cmp = 0;
    logic        overtemp_cmp = 0, charge_pump_uv_cmp = 0, current_forward_cmp = 1;
    logic        latch_off_strap = 0, hsel = 0, hwrite = 0, load_wakeup_cmp = 0;
    logic [11:0] load_current_code = 12'h000;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic        main_gate_en, bypass_gate_en, wake_out, load_current_monitor;
    logic        temp_monitor_en, fault_flag_n_o, fault_flag_n_oe, current_dir_o;
    logic        current_dir_oe, hreadyout, hresp, flt_pin, dir_pin;
    int          n_fail = 0, n_compared = 0;
    always #2.5 clk_sys = !clk_sys;
    swfp_ctrl #(.RETRY_HALF(4), .DEASSERT(3)) u_swfp_ctrl
    (
        .clk_sys, .arst_n, .on_request_in, .low_power_request_n, .enable_undervoltage_in,
        .supply_good_in, .short_circuit_cmp, .overtemp_cmp, .charge_pump_uv_cmp,
        .current_forward_cmp, .load_wakeup_cmp, .latch_off_strap, .load_current_code,
        .main_gate_en, .bypass_gate_en, .wake_out, .load_current_monitor, .temp_monitor_en,
        .fault_flag_n_in(flt_pin), .fault_flag_n_o, .fault_flag_n_oe, .current_dir_o,
        .current_dir_oe, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
        .hwdata, .hrdata, .hreadyout, .hresp
    );
    swfp_host u_swfp_host
    (
        .flt_oe(fault_flag_n_oe), .dir_oe(current_dir_oe), .flt_pin, .dir_pin
    );
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic stop_test();
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Expected levels are main gate, fault pin, bypass gate in that order.
    task automatic pins(input logic [2:0] e, input string m);
        chk({29'h0, main_gate_en, flt_pin, bypass_gate_en}, {29'h0, e}, m);
    endtask
    task automatic wait_main(input logic v, input int n);
        for (int i = 0; i < n && main_gate_en !== v; i++)
            @(posedge clk_sys);
        chk({31'h0, main_gate_en}, {31'h0, v}, "main gate wait");
    endtask
    // Single AHB transfer; called just after a rising edge.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
        ahb(1'b0, a, 32'h0);
        chk(rd, e, m);
    endtask
    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        cyc(6);
        arst_n <= 1'b1;
        cyc(1);
        rchk(OFS_OC_STRT, {20'h0, RST_OC_START}, "oc start reset");
        rchk(OFS_I2T_TRP, RST_I2T_TRIP, "trip reset");
        rchk(8'h20, 32'h0, "unmapped read");
        chk({31'h0, hresp}, 32'h0, "okay response");
        ahb(1'b1, OFS_CTRL, 32'h1);
        rchk(OFS_CTRL, 32'h1, "ctrl readback");
        ahb(1'b1, OFS_CTRL, 32'h0);
        {enable_undervoltage_in, supply_good_in, on_request_in} <= 3'h7;
        cyc(8);
        pins(3'b110, "active gates");
        chk({29'h0, load_current_monitor, temp_monitor_en, wake_out}, 32'h6, "monitors");
        chk({31'h0, dir_pin}, 32'h1, "forward dir");
        current_forward_cmp <= 1'b0;
        cyc(6);
        chk({31'h0, dir_pin}, 32'h0, "reverse dir");
        short_circuit_cmp <= 1'b1;
        wait_main(1'b0, SC_RESP_CYC);
        pins(3'b000, "short trip");
        short_circuit_cmp <= 1'b0;
        cyc(240);
        chk({31'h0, main_gate_en}, 32'h0, "retry early");
        wait_main(1'b1, 40);
        chk({31'h0, flt_pin}, 32'h0, "fault held");
        cyc(8);
        pins(3'b110, "retry done");
        ahb(1'b1, OFS_OC_STRT, 32'h10);
        ahb(1'b1, OFS_I2T_TRP, 32'h100);
        latch_off_strap <= 1'b1;
        load_current_code <= 12'h011;
        cyc(4);
        chk({31'h0, main_gate_en}, 32'h1, "integrating");
        wait_main(1'b0, 20);
        pins(3'b000, "overcurrent trip");
        load_current_code <= 12'h000;
        cyc(300);
        pins(3'b000, "latched off");
        on_request_in <= 1'b0;
        cyc(8);
        on_request_in <= 1'b1;
        wait_main(1'b1, 10);
        latch_off_strap <= 1'b0;
        overtemp_cmp <= 1'b1;
        wait_main(1'b0, 8);
        overtemp_cmp <= 1'b0;
        cyc(300);
        pins(3'b000, "overtemp latched");
        rchk(OFS_STATUS, 32'h0000_0032, "status overtemp");
        low_power_request_n <= 1'b0;
        cyc(12);
        pins(3'b011, "low power");
        chk({29'h0, load_current_monitor, temp_monitor_en, wake_out}, 32'h1, "lp mon");
        load_wakeup_cmp <= 1'b1;
        cyc(6);
        pins(3'b110, "load wakeup");
        chk({29'h0, load_current_monitor, temp_monitor_en, wake_out}, 32'h6, "wk mon");
        load_wakeup_cmp <= 1'b0;
        low_power_request_n <= 1'b1;
        cyc(12);
        pins(3'b110, "back active");
        charge_pump_uv_cmp <= 1'b1;
        cyc(6);
        pins(3'b000, "pump low");
        charge_pump_uv_cmp <= 1'b0;
        cyc(12);
        pins(3'b110, "pump back");
        stop_test();
    end
    initial
    begin
        #200000;
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire
